// ### verilog/meter_cmd.sv
// Two-channel meter command interpreter with APB register access
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "meter_defines.svh"

// Overview of operation
// - Enable query answers the event enable register content as an integer.
// - Event status query answers the event status register as an integer.
// - Clear-status empties event, error, operation registers and error queue.
// - Mean-count command stores the given value (zero stores 1) for channel 1 or 2.
// - Mean-count query answers the channel's stored count as an integer.
// - Averaging touches only host answers; the display uses unaveraged offset-corrected readings.
// - Power query answers channel optical power in watts as a float.
// - Overflow answers signed infinity instead of power, current or voltage.
// - Current query answers channel photodiode current in amperes as float.
// - Thermopile voltage query is accepted for channel 1 only, as float.
// - Offset query answers the channel's applied offset as a float.
// - Calibrate measures and stores a new offset; later readings use it.
// - Calibration runs several seconds; host waits before trusting results.
// - Enable command loads the given value into the event enable register.
module meter_cmd
    import meter_pkg::*;
#(
    parameter int SAMPLE_DIV = `SAMPLE_DIV,
    parameter int ZERO_LOG2  = `ZERO_LOG2
) (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output var  logic [31:0]        prdata,
    output var  logic               pready,
    output var  logic               pslverr,
    // Converter samples
    input  wire meter_pkg::sample_t adc_amps_ch1,
    input  wire meter_pkg::sample_t adc_amps_ch2,
    input  wire meter_pkg::sample_t adc_volt_ch1,
    input  wire logic               sensor_thermal,
    // Front display and interrupt
    output var  logic signed [16:0] display_ch1,
    output var  logic signed [16:0] display_ch2,
    output var  logic               irq
);
    import meter_pkg::*;

    // The averager's serial divide needs about 35 clocks between samples
    initial
    begin
        if (SAMPLE_DIV < 40 || ZERO_LOG2 < 1 || ZERO_LOG2 > 16)
            $error("meter_cmd: unsupported parameters");
    end

    // Suffix 0 means omitted, which selects channel 1
    function automatic logic [1:0] chan_of(input logic [1:0] sfx);
        logic [1:0] r;
        r = {1'b0, 1'b0};
        case (sfx)
            2'd0, 2'd1: r = 2'b10;
            2'd2:       r = 2'b11;
            default:    r = 2'b00;
        endcase
        return r;
    endfunction : chan_of

    localparam int DW = $clog2(SAMPLE_DIV);
    localparam int ZW = 16 + ZERO_LOG2;

    cmd_state_e   state;
    logic [DW-1:0] div_cnt;
    logic          sample_en;
    sample_t       raw [2];
    logic signed [16:0] corr [2];
    logic signed [16:0] mean [2];
    logic          mean_vld [2];
    logic signed [16:0] mean_q [2];
    logic [15:0]   mean_cnt [2];
    sample_t       null_ofs [2];
    logic [1:0]    ovf_pos;
    logic [1:0]    ovf_neg;
    logic          null_busy;
    logic          null_ch;
    logic signed [ZW-1:0] null_acc;
    logic [ZERO_LOG2-1:0] null_n;
    logic          null_done;
    logic [7:0]    esr;
    logic [7:0]    ese;
    logic [3:0]    dee;
    logic          doe;
    logic [3:0]    err_cnt;
    logic [7:0]    err_last;
    logic [2:0]    isr;
    logic [2:0]    imr;
    word_t         resp_int;
    logic          resp_float;
    logic          resp_vld;
    logic signed [31:0] conv_val;
    logic signed [7:0]  conv_exp;
    word_t         conv_fp;
    word_t         pwdata_arg;
    logic          setup;
    logic          access;
    logic          wr_cmd;
    logic [3:0]    op;
    logic [1:0]    chs;
    logic          ch;
    logic          cmd_ok;
    logic [7:0]    err_code;
    logic          do_cls;
    logic          rd_isr;
    logic          rd_resp;
    logic          rd_errq;
    logic [7:0]    dev_err;

    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    assign wr_cmd = access && pwrite && paddr == `OFS_CMD;
    assign rd_isr = access && !pwrite && paddr == `OFS_ISR;
    assign rd_resp = access && !pwrite && paddr == `OFS_RESP;
    assign rd_errq = access && !pwrite && paddr == `OFS_ERRQ;
    assign op = pwdata[`CMD_OP_LSB +: 4];
    assign chs = chan_of(pwdata[`CMD_CH_LSB +: 2]);
    assign ch = chs[0];
    assign raw[0] = sensor_thermal ? adc_volt_ch1 : adc_amps_ch1;
    assign raw[1] = adc_amps_ch2;

    // Command validity and error codes
    always_comb
    begin
        cmd_ok = 1'b1;
        err_code = 8'h00;
        if (op > `OP_NULL_CAL)
        begin
            cmd_ok = 1'b0;
            err_code = `ERR_BAD_OP;
        end
        else if (!chs[1] || (op == `OP_EMF && ch))
        begin
            cmd_ok = 1'b0;
            err_code = `ERR_BAD_CH;
        end
        else if (state != ST_IDLE || (op == `OP_NULL_CAL && null_busy))
        begin
            cmd_ok = 1'b0;
            err_code = `ERR_BUSY;
        end
    end
    assign do_cls = wr_cmd && cmd_ok && op == `OP_CLS;

    // Fixed sample tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt <= '0;
            sample_en <= 1'b0;
        end
        else
        begin
            sample_en <= div_cnt == DW'(SAMPLE_DIV - 1);
            if (div_cnt == DW'(SAMPLE_DIV - 1))
                div_cnt <= '0;
            else
                div_cnt <= div_cnt + DW'(1);
        end
    end

    generate
        for (genvar c = 0; c < 2; c++)
        begin : g_chan
            assign corr[c] = 17'(raw[c]) - 17'(null_ofs[c]);

            mean_filter #(
                .W  (17),
                .CW (16)
            ) u_mean (
                .pclk      (pclk),
                .presetn   (presetn),
                .sample_en (sample_en),
                .sample    (corr[c]),
                .count     (mean_cnt[c]),
                .mean      (mean[c]),
                .mean_vld  (mean_vld[c])
            );

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    mean_q[c] <= '0;
                    ovf_pos[c] <= 1'b0;
                    ovf_neg[c] <= 1'b0;
                end
                else
                begin
                    if (mean_vld[c])
                        mean_q[c] <= mean[c];
                    if (sample_en)
                    begin
                        ovf_pos[c] <= raw[c] == 16'sh7fff;
                        ovf_neg[c] <= raw[c] == -16'sh8000;
                    end
                end
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    mean_cnt[c] <= `MEAN_RESET;
                else if (wr_cmd && cmd_ok && op == `OP_MEAN_SET
                         && ch == 1'(c))
                    // A zero count would close a block only after 65536 samples, dividing by zero
                    mean_cnt[c] <= (pwdata_arg == 32'h0) ? `MEAN_RESET
                                   : pwdata_arg[15:0];
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    null_ofs[c] <= '0;
                else if (null_busy && null_ch == 1'(c) && sample_en
                         && null_n == '1)
                    null_ofs[c] <= sample_t'(
                        (null_acc + ZW'(raw[c])) >>> ZERO_LOG2);
            end
        end
    endgenerate

    // Display ignores the mean count entirely
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            display_ch1 <= '0;
            display_ch2 <= '0;
        end
        else if (sample_en)
        begin
            display_ch1 <= corr[0];
            display_ch2 <= corr[1];
        end
    end

    // Offset acquisition spans 2**ZERO_LOG2 samples, a few seconds
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            null_busy <= 1'b0;
            null_ch <= 1'b0;
            null_acc <= '0;
            null_n <= '0;
            null_done <= 1'b0;
        end
        else
        begin
            null_done <= 1'b0;
            if (wr_cmd && cmd_ok && op == `OP_NULL_CAL)
            begin
                null_busy <= 1'b1;
                null_ch <= ch;
                null_acc <= '0;
                null_n <= '0;
            end
            else if (null_busy && sample_en)
            begin
                null_acc <= null_acc + ZW'(raw[null_ch]);
                null_n <= null_n + ZERO_LOG2'(1);
                if (null_n == '1)
                begin
                    null_busy <= 1'b0;
                    null_done <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pwdata_arg <= '0;
        else if (access && pwrite && paddr == `OFS_ARG)
            pwdata_arg <= pwdata;
    end

    // Command execution and answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ST_IDLE;
            resp_int <= '0;
            resp_float <= 1'b0;
            resp_vld <= 1'b0;
            conv_val <= '0;
            conv_exp <= '0;
            ese <= '0;
        end
        else
        begin
            if (state == ST_CONV)
            begin
                state <= ST_IDLE;
                resp_vld <= 1'b1;
            end
            else if (rd_resp)
                resp_vld <= 1'b0;
            if (wr_cmd && cmd_ok)
            begin
                resp_float <= 1'b0;
                case (op)
                    `OP_ESE_SET:
                        ese <= pwdata_arg[7:0];
                    `OP_ESE_QUERY:
                        resp_int <= 32'(ese);
                    `OP_ESR_QUERY:
                        resp_int <= 32'(esr);
                    `OP_MEAN_QUERY:
                        resp_int <= 32'(mean_cnt[ch]);
                    `OP_WATTS, `OP_AMPS, `OP_EMF:
                    begin
                        conv_val <= 32'(mean_q[ch]);
                        conv_exp <= (op == `OP_WATTS) ? `WATTS_LSB_EXP
                                  : (op == `OP_AMPS) ? `AMPS_LSB_EXP
                                  : `EMF_LSB_EXP;
                        resp_float <= !(ovf_pos[ch] || ovf_neg[ch]);
                        resp_int <= ovf_pos[ch] ? `FP_POS_INF
                                  : `FP_NEG_INF;
                    end
                    `OP_NULL_QUERY:
                    begin
                        conv_val <= 32'(null_ofs[ch]);
                        conv_exp <= (sensor_thermal && !ch)
                                  ? `EMF_LSB_EXP : `AMPS_LSB_EXP;
                        resp_float <= 1'b1;
                    end
                    default:
                        resp_int <= resp_int;
                endcase
                if (op != `OP_ESE_SET && op != `OP_CLS
                    && op != `OP_MEAN_SET && op != `OP_NULL_CAL)
                begin
                    state <= ST_CONV;
                    resp_vld <= 1'b0;
                end
            end
        end
    end

    float_pack u_fp (
        .pclk    (pclk),
        .presetn (presetn),
        .value   (conv_val),
        .scale   (conv_exp),
        .fp      (conv_fp)
    );

    // Status registers: events win over a simultaneous clear
    assign dev_err = {4'h0, ovf_neg[1], ovf_pos[1], ovf_neg[0], ovf_pos[0]};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            esr <= '0;
            dee <= '0;
            doe <= 1'b0;
            err_cnt <= '0;
            err_last <= '0;
        end
        else
        begin
            if (do_cls)
            begin
                esr <= '0;
                dee <= '0;
                doe <= 1'b0;
                err_cnt <= '0;
                err_last <= '0;
            end
            else if (wr_cmd && cmd_ok && op == `OP_ESR_QUERY)
                esr <= '0;
            else if (rd_errq && err_cnt != 4'h0)
                err_cnt <= err_cnt - 4'h1;
            dee <= (do_cls ? 4'h0 : dee) | dev_err[3:0];
            if (null_done)
            begin
                doe <= 1'b1;
                esr[`ESR_OPC] <= 1'b1;
            end
            if (wr_cmd && !cmd_ok)
            begin
                esr[(err_code == `ERR_BUSY) ? `ESR_EXE : `ESR_CME] <= 1'b1;
                err_last <= err_code;
                if (err_cnt != 4'hf)
                    err_cnt <= err_cnt + 4'h1;
            end
        end
    end

    // Interrupt status clears on read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            isr <= '0;
            imr <= '0;
            irq <= 1'b0;
        end
        else
        begin
            isr <= (rd_isr ? 3'b000 : isr)
                 | {wr_cmd && !cmd_ok, null_done, state == ST_CONV};
            if (access && pwrite && paddr == `OFS_IMR)
                imr <= pwdata[2:0];
            irq <= |(isr & imr);
        end
    end

    // APB answer: one access cycle, data registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup;
            pslverr <= 1'b0;
            prdata <= '0;
            if (setup)
            begin
                case (paddr)
                    `OFS_CMD, `OFS_IMR:
                        prdata <= (paddr == `OFS_IMR) ? 32'(imr) : 32'h0;
                    `OFS_ARG:  prdata <= pwdata_arg;
                    `OFS_RESP: prdata <= resp_float ? conv_fp : resp_int;
                    `OFS_STAT: prdata <= 32'({ovf_neg[1], ovf_pos[1],
                                   ovf_neg[0], ovf_pos[0], null_busy,
                                   resp_vld});
                    `OFS_ESR:  prdata <= 32'(esr);
                    `OFS_ESE:  prdata <= 32'(ese);
                    `OFS_DEE:  prdata <= 32'(dee);
                    `OFS_DOE:  prdata <= 32'(doe);
                    `OFS_ERRQ: prdata <= {16'h0, 4'h0, err_cnt, err_last};
                    `OFS_ISR:  prdata <= 32'(isr);
                    default:   pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule : meter_cmd
`default_nettype wire

// ### verilog/meter_defines.svh
// Register offsets, field positions, command codes and timing constants
`ifndef METER_DEFINES_SVH
`define METER_DEFINES_SVH

`define CLK_HZ            10000000
`define SAMPLE_RATE_HZ    500
`define SAMPLE_DIV        (`CLK_HZ / `SAMPLE_RATE_HZ)
`define ZERO_LOG2         11

`define OFS_CMD           8'h00
`define OFS_ARG           8'h04
`define OFS_RESP          8'h08
`define OFS_STAT          8'h0c
`define OFS_ESR           8'h10
`define OFS_ESE           8'h14
`define OFS_DEE           8'h18
`define OFS_DOE           8'h1c
`define OFS_ERRQ          8'h20
`define OFS_ISR           8'h24
`define OFS_IMR           8'h28

`define CMD_OP_LSB        0
`define CMD_CH_LSB        4

`define OP_ESE_SET        4'h0
`define OP_ESE_QUERY      4'h1
`define OP_ESR_QUERY      4'h2
`define OP_CLS            4'h3
`define OP_MEAN_SET       4'h4
`define OP_MEAN_QUERY     4'h5
`define OP_WATTS          4'h6
`define OP_AMPS           4'h7
`define OP_EMF            4'h8
`define OP_NULL_QUERY     4'h9
`define OP_NULL_CAL       4'ha

`define ESR_OPC           0
`define ESR_EXE           4
`define ESR_CME           5

`define ERR_BAD_OP        8'h01
`define ERR_BAD_CH        8'h02
`define ERR_BUSY          8'h03

`define IRQ_RESP          0
`define IRQ_NULL_DONE     1
`define IRQ_ERR           2

`define FP_POS_INF        32'h7f800000
`define FP_NEG_INF        32'hff800000
`define WATTS_LSB_EXP     8'shec
`define AMPS_LSB_EXP      8'she8
`define EMF_LSB_EXP       8'shf0
`define MEAN_RESET        16'h0001

`endif

// ### verilog/meter_pkg.sv
// Types shared by the meter command block
`default_nettype none
package meter_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_CONV} cmd_state_e;
    typedef logic [31:0] word_t;
    typedef logic signed [15:0] sample_t;
endpackage : meter_pkg
`default_nettype wire

// ### verilog/mean_filter.sv
// Block averager: sums a set count of samples and divides serially
`timescale 1ns/1ps
`default_nettype none
module mean_filter #(
    parameter int W  = 17,
    parameter int CW = 16
) (
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // Sample stream
    input  wire logic                sample_en,
    input  wire logic signed [W-1:0] sample,
    input  wire logic [CW-1:0]       count,
    // Result
    output var  logic signed [W-1:0] mean,
    output var  logic                mean_vld
);
    localparam int SW = W + CW;
    localparam int STW = $clog2(SW + 1);

    initial
    begin
        if (W < 8 || CW < 2 || W > 32)
            $error("mean_filter: unsupported widths");
    end

    logic signed [SW-1:0] sum;
    logic signed [SW-1:0] total;
    logic [CW-1:0]        n;
    logic [CW-1:0]        div;
    logic [SW-1:0]        dvd;
    logic [SW-1:0]        quo;
    logic [CW:0]          rem;
    logic [CW:0]          rsh;
    logic [STW-1:0]       step;
    logic                 busy;
    logic                 neg;

    assign total = sum + SW'(sample);
    assign rsh = {rem[CW-1:0], dvd[SW-1]};

    // Division runs in the gap between samples, far shorter than one period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sum <= '0;
            n <= '0;
            busy <= 1'b0;
            neg <= 1'b0;
            div <= '0;
            dvd <= '0;
            quo <= '0;
            rem <= '0;
            step <= '0;
        end
        else
        begin
            if (sample_en)
            begin
                if (n >= count - CW'(1))
                begin
                    sum <= '0;
                    n <= '0;
                    busy <= 1'b1;
                    neg <= total[SW-1];
                    dvd <= total[SW-1] ? SW'(-total) : SW'(total);
                    div <= count;
                    quo <= '0;
                    rem <= '0;
                    step <= '0;
                end
                else
                begin
                    sum <= total;
                    n <= n + CW'(1);
                end
            end
            if (busy && !sample_en)
            begin
                dvd <= {dvd[SW-2:0], 1'b0};
                if (rsh >= {1'b0, div})
                begin
                    rem <= rsh - {1'b0, div};
                    quo <= {quo[SW-2:0], 1'b1};
                end
                else
                begin
                    rem <= rsh;
                    quo <= {quo[SW-2:0], 1'b0};
                end
                step <= step + STW'(1);
                if (step == STW'(SW))
                    busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mean <= '0;
            mean_vld <= 1'b0;
        end
        else
        begin
            mean_vld <= 1'b0;
            if (busy && !sample_en && step == STW'(SW))
            begin
                mean <= neg ? -W'(quo) : W'(quo);
                mean_vld <= 1'b1;
            end
        end
    end
endmodule : mean_filter
`default_nettype wire

// ### verilog/float_pack.sv
// Signed integer times a power of two to single-precision float
`timescale 1ns/1ps
`default_nettype none
module float_pack (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // Operand
    input  wire logic signed [31:0] value,
    input  wire logic signed [7:0]  scale,
    // Result, one cycle later
    output var  logic [31:0]        fp
);
    function automatic logic [4:0] msb_of(input logic [31:0] v);
        logic [4:0] p;
        p = '0;
        for (int i = 0; i < 32; i++)
            if (v[i])
                p = 5'(i);
        return p;
    endfunction : msb_of

    logic [31:0] mag;
    logic [4:0]  p;
    logic [31:0] norm;
    logic [9:0]  ex;

    assign mag = value[31] ? 32'(-value) : 32'(value);
    assign p = msb_of(mag);
    assign norm = mag << (5'd31 - p);
    // Exponent range is not clamped: scale constants keep it in range
    assign ex = 10'd127 + 10'(p) + 10'(scale);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fp <= '0;
        else if (mag == 32'h0)
            fp <= '0;
        else
            fp <= {value[31], ex[7:0], norm[30:8]};
    end
endmodule : float_pack
`default_nettype wire

// ### tb/apb_host.sv
// Host-side APB master model, one transfer at a time
`timescale 1ns/1ps
`default_nettype none
module apb_host (
    // APB master side
    input  wire logic        pclk,
    input  wire logic        pready,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [7:0]  paddr,
    output var  logic [31:0] pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // Request is held until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask : xfer
endmodule : apb_host
`default_nettype wire

// ### tb/meter_cmd_props.sv
// Bus timing and display pacing assertions for the meter command block
`timescale 1ns/1ps
`default_nettype none
module meter_cmd_props (
    // Clock, reset and APB
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    // Front display
    input wire logic signed [16:0] display_ch1,
    input wire logic signed [16:0] display_ch2
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire setup = psel && !penable;
    a_ready_no_wait: assert property (setup |=> pready)
        else $error("pready late");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_err_zero_data: assert property (pslverr |-> pready && !prdata)
        else $error("error with data");
    a_unmapped_err: assert property (setup && paddr > 8'h28 |=> pslverr)
        else $error("unmapped not refused");
    a_mapped_ok: assert property (
        setup && !pwrite && paddr <= 8'h28 && paddr[1:0] == 2'b00
        |=> !pslverr)
        else $error("mapped read refused");
    a_disp1_paced: assert property (
        $changed(display_ch1) |=> $stable(display_ch1) [*8])
        else $error("display 1 not paced");
    a_disp2_paced: assert property (
        $changed(display_ch2) |=> $stable(display_ch2) [*8])
        else $error("display 2 not paced");
    cover property (setup && !pwrite && paddr == 8'h08);
    cover property (pslverr);
    cover property ($changed(display_ch1));
endmodule : meter_cmd_props
`default_nettype wire

// ### tb/meter_status_and_measure_cmds_tb.sv
// Self-checking bench for the meter command block
`timescale 1ns/1ps
`default_nettype none
`include "meter_defines.svh"
module meter_status_and_measure_cmds_tb;
    import meter_pkg::*;
    logic        pclk = 0, presetn = 0, sensor_thermal = 0;
    logic        psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, v;
    sample_t     adc_amps_ch1 = 0, adc_amps_ch2 = 0, adc_volt_ch1 = 0;
    logic [32:0] q[$];
    logic signed [16:0] display_ch1, display_ch2;
    int          num_errors = 0, n_checks = 0, cyc = 0;
    always #50 pclk = ~pclk;
    apb_host host (.pclk, .pready, .psel, .penable, .pwrite, .paddr,
                   .pwdata);
    // Short tick and calibration counts keep the run brief
    meter_cmd #(.SAMPLE_DIV(40), .ZERO_LOG2(2)) DUT (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .adc_amps_ch1, .adc_amps_ch2, .adc_volt_ch1,
        .sensor_thermal, .display_ch1, .display_ch2, .irq);
    task automatic check(input logic [32:0] s, input logic [32:0] e);
        n_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask : check
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        q.push_back(e);
        host.xfer(1'b0, a, 32'h0);
    endtask : rd
    task automatic cmd(input logic [5:0] c, input logic [31:0] a);
        host.xfer(1'b1, `OFS_ARG, a);
        host.xfer(1'b1, `OFS_CMD, {26'h0, c});
    endtask : cmd
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite)
            check({pslverr, prdata}, q.pop_front());
    initial
    begin
        void'($urandom(83351));
        v = $urandom & 32'hff;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        host.xfer(1'b1, `OFS_IMR, 32'h1);
        cmd(6'h00, v);
        cmd(6'h01, 0);
        repeat (3) @(negedge pclk);
        check(33'(irq), 33'h1);
        rd(`OFS_RESP, {1'b0, v});
        rd(`OFS_ISR, 33'h1);
        repeat (3) @(negedge pclk);
        check(33'(irq), 33'h0);
        cmd(6'h0b, 0);
        cmd(6'h02, 0);
        rd(`OFS_RESP, 33'h20);
        cmd(6'h31, 0);
        cmd(6'h03, 0);
        cmd(6'h02, 0);
        rd(`OFS_RESP, 33'h0);
        rd(`OFS_ERRQ, 33'h0);
        sensor_thermal <= 1'b1;
        adc_volt_ch1 <= 16'h7fff;
        adc_amps_ch2 <= 16'h8000;
        repeat (50) @(posedge pclk);
        check({16'h0, display_ch1}, 33'h07fff);
        check({16'h0, display_ch2}, 33'h18000);
        cmd(6'h08, 0);
        rd(`OFS_RESP, {1'b0, `FP_POS_INF});
        cmd(6'h27, 0);
        rd(`OFS_RESP, {1'b0, `FP_NEG_INF});
        cmd(6'h26, 0);
        rd(`OFS_RESP, {1'b0, `FP_NEG_INF});
        cmd(6'h24, 25);
        cmd(6'h25, 0);
        rd(`OFS_RESP, 33'd25);
        cmd(6'h04, 10);
        cmd(6'h15, 0);
        rd(`OFS_RESP, 33'd10);
        v = $urandom % 8;
        adc_amps_ch2 <= 16'h1 << v;
        cmd(6'h2a, 0);
        cmd(6'h2a, 0);
        rd(`OFS_ERRQ, 33'h103);
        repeat (250) @(posedge pclk);
        cmd(6'h29, 0);
        rd(`OFS_RESP, {2'b0, 8'(103 + v), 23'h0});
        check({16'h0, display_ch2}, 33'h0);
        rd(8'h40, {1'b1, 32'h0});
        end_of_test();
    end
endmodule : meter_status_and_measure_cmds_tb
bind meter_cmd meter_cmd_props u_props (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .display_ch1,
    .display_ch2);
`default_nettype wire
